// File: core/sts_bank_fsm.sv
// bank state logic of the two-bank memory: transient states and command legality
// assumes the controller drives the pins from mclk; commands other than refresh and mode load are judged per bank
`timescale 1ns/1ps
module sts_bank_fsm
    import sts_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    sts_if.dev                pins,
    input  wire logic         burst_done,
    output logic [7:0]        bank_state,
    output logic              cmd_illegal,
    output logic              cmd_accepted
);
    typedef struct packed {
        sts_state_e [NUM_BANKS-1:0]            st;
        logic [NUM_BANKS-1:0][CNT_W-1:0]       cnt;
        logic                                  illegal;
        logic                                  accepted;
    } sts_dev_s;

    sts_dev_s s_r, s_nxt;
    logic [3:0] code;
    logic       b;
    logic       mode_cmd;

    assign code = {pins.chip_select_n, pins.row_strobe_n, pins.column_strobe_n, pins.write_strobe_n};
    assign b = pins.bank_select_bit;
    assign mode_cmd = (code == 4'h0);

    always_comb begin
        s_nxt = s_r;
        s_nxt.illegal = 1'b0;
        s_nxt.accepted = 1'b0;
        // timers run per bank; a finished wait moves the bank on
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (s_r.cnt[i] != CNT_ZERO) begin
                s_nxt.cnt[i] = s_r.cnt[i] - CNT_ONE;
            end
            if (s_r.cnt[i] == CNT_ONE) begin
                unique case (s_r.st[i])
                    STS_ACTIVATING, STS_WRITE_RECOV: s_nxt.st[i] = STS_ROW_ACTIVE;
                    STS_WRITE_RECOV_AP, STS_REFRESH, STS_MODE_LOAD: s_nxt.st[i] = STS_IDLE;
                    default: s_nxt.st[i] = s_r.st[i];
                endcase
            end
        end
        // a write burst ending in a row-active bank starts write recovery
        if (burst_done && s_r.st[b] == STS_ROW_ACTIVE) begin
            s_nxt.st[b] = pins.auto_precharge ? STS_WRITE_RECOV_AP : STS_WRITE_RECOV;
            s_nxt.cnt[b] = pins.auto_precharge ? 4'(DAL_CYC) : 4'(DPL_CYC);
        end
        // commands sampled on this edge only decode
        if (!pins.chip_select_n && code != 4'h7 && code != 4'h6) begin
            // refresh and mode load act on the device, so both banks must permit them
            if (code == 4'h1 || mode_cmd) begin
                if (s_r.st[0] == STS_IDLE && s_r.st[1] == STS_IDLE) begin
                    s_nxt.accepted = 1'b1;
                    for (int i = 0; i < NUM_BANKS; i++) begin
                        s_nxt.st[i] = mode_cmd ? STS_MODE_LOAD : STS_REFRESH;
                        s_nxt.cnt[i] = mode_cmd ? 4'(T_MCD_CYC) : 4'(RP_CYC);
                    end
                end else begin
                    s_nxt.illegal = 1'b1;
                end
            end else begin
                unique case (s_r.st[b])
                    STS_IDLE: begin
                        if (code == 4'h3) begin
                            s_nxt.st[b] = STS_ACTIVATING;
                            s_nxt.cnt[b] = 4'(RCD_CYC);
                            s_nxt.accepted = 1'b1;
                        end else begin
                            s_nxt.illegal = (code != 4'h2);
                            s_nxt.accepted = (code == 4'h2);
                        end
                    end
                    STS_ROW_ACTIVE: begin
                        s_nxt.accepted = 1'b1;
                        if (code == 4'h2) begin
                            s_nxt.st[b] = STS_IDLE;
                        end else if (code == 4'h3) begin
                            s_nxt.illegal = 1'b1;
                            s_nxt.accepted = 1'b0;
                        end
                    end
                    STS_WRITE_RECOV: begin
                        if (code == 4'h5 || code == 4'h4) begin
                            s_nxt.st[b] = STS_ROW_ACTIVE; // read starts or write restarts at once
                            s_nxt.cnt[b] = CNT_ZERO;
                            s_nxt.accepted = 1'b1;
                        end else begin
                            s_nxt.illegal = 1'b1;
                        end
                    end
                    default: s_nxt.illegal = 1'b1; // busy bank refuses all
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bank_state = {s_r.st[1], s_r.st[0]};
    assign cmd_illegal = s_r.illegal;
    assign cmd_accepted = s_r.accepted;
endmodule // sts_bank_fsm

// File: core/sts_cmd_issuer.sv
// controller end: issues one command per request, holding off while the target bank is busy
// assumes the requester holds req until ack; the issuer tracks its own copy of bank timing
`timescale 1ns/1ps
module sts_cmd_issuer
    import sts_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    sts_if.ctrl               pins,
    input  wire logic         req,
    input  wire logic [2:0]   req_op,
    input  wire logic         req_bank,
    input  wire logic         req_ap,
    input  wire logic         req_write_done,
    output logic              ack
);
    typedef struct packed {
        logic [NUM_BANKS-1:0][CNT_W-1:0] busy;
        logic [CNT_W-1:0]                rrd;
        logic [3:0]                      code;
        logic                            bank;
        logic                            ap;
        logic                            ack;
    } sts_ctl_s;

    sts_ctl_s c_r, c_nxt;
    logic     go;
    logic     dev_wide;

    assign dev_wide = (req_op == 3'(STS_CMD_REF_MODE));

    always_comb begin
        c_nxt = c_r;
        c_nxt.ack = 1'b0;
        c_nxt.code = 4'h7;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (c_r.busy[i] != CNT_ZERO) c_nxt.busy[i] = c_r.busy[i] - CNT_ONE;
        end
        if (c_r.rrd != CNT_ZERO) c_nxt.rrd = c_r.rrd - CNT_ONE;
        // idle commands are always allowed; others wait for the bank timers
        go = req && !c_r.ack;
        if (req_op > 3'(STS_CMD_BST)) begin
            go = go && (c_r.busy[req_bank] == CNT_ZERO);
            if (dev_wide) go = go && c_r.busy[0] == CNT_ZERO && c_r.busy[1] == CNT_ZERO;
            if (req_op == 3'(STS_CMD_ACT)) go = go && c_r.rrd == CNT_ZERO;
        end
        if (go) begin
            c_nxt.code = sts_encode(req_op);
            c_nxt.bank = req_bank;
            c_nxt.ap = req_ap;
            c_nxt.ack = 1'b1;
            unique case (req_op)
                3'(STS_CMD_ACT): begin
                    c_nxt.busy[req_bank] = 4'(RCD_CYC);
                    c_nxt.rrd = 4'(RRD_CYC);
                end
                3'(STS_CMD_REF_MODE): begin
                    c_nxt.busy[0] = 4'(RP_CYC);
                    c_nxt.busy[1] = 4'(RP_CYC);
                end
                default: ;
            endcase
        end
        // end of a write burst: recovery blocks all but idle commands on that bank, column commands included
        if (req_write_done) begin
            c_nxt.busy[req_bank] = req_ap ? 4'(DAL_CYC) : 4'(DPL_CYC);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            c_r <= '0;
            c_r.code <= 4'h8;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign {pins.chip_select_n, pins.row_strobe_n, pins.column_strobe_n, pins.write_strobe_n} = c_r.code;
    assign pins.bank_select_bit = c_r.bank;
    assign pins.auto_precharge = c_r.ap;
    assign ack = c_r.ack;
endmodule // sts_cmd_issuer

// File: dv/sts_checker.sv
// assertions on the command pins between issuer and bank logic, and on the bank logic answers
// assumes one clock mclk, asynchronous active-high rst
// cmd is {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
`timescale 1ns/1ps
module sts_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       chip_select_n,
    input wire logic       row_strobe_n,
    input wire logic       column_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       bank_select_bit,
    input wire logic [7:0] bank_state,
    input wire logic       cmd_illegal,
    input wire logic       cmd_accepted
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] cmd;
    assign cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
    sequence act0_s; cmd == 4'h3 && !bank_select_bit && bank_state[3:0] == 4'h0; endsequence
    sequence open0_s; bank_state[3:0] == 4'h1 && cmd_accepted ##1 bank_state[3:0] == 4'h2; endsequence
    sequence act1_s; cmd == 4'h3 && bank_select_bit && bank_state[7:4] == 4'h0; endsequence
    // deselect ignores the other pins, so only cs_n is looked at for it
    sequence quiet_s; chip_select_n || cmd[3:1] == 3'h3; endsequence
    row_open_a: assert property (act0_s |=> open0_s) else $error("row did not open");
    open_hold_a: assert property ((bank_state[3:0] == 4'h1 && !bank_select_bit) |-> quiet_s)
        else $error("command sent while row opening");
    recov_hold_a: assert property ((bank_state[3:0] == 4'h3 && !bank_select_bit) |->
        !(cmd inside {4'h3, 4'h2, 4'h1, 4'h0}))
        else $error("row or refresh command in recovery");
    recov_end_a: assert property (bank_state[3:0] == 4'h3 |-> ##[1:3] bank_state[3:0] == 4'h2)
        else $error("recovery did not end");
    ap_hold_a: assert property ((bank_state[7:4] == 4'h4 && bank_select_bit) |-> quiet_s)
        else $error("command sent in auto-precharge recovery");
    ap_end_a: assert property (bank_state[7:4] == 4'h4 |-> ##[1:3] bank_state[7:4] == 4'h0)
        else $error("auto-precharge recovery did not end");
    refresh_hold_a: assert property (bank_state == 8'h55 |-> quiet_s) else $error("command during refresh");
    refresh_end_a: assert property ($rose(bank_state == 8'h55) |-> ##[1:3] bank_state == 8'h00)
        else $error("refresh did not end");
    idle_cmd_a: assert property (quiet_s |=> !cmd_illegal) else $error("idle command refused");
    bank_split_a: assert property (act1_s |=> bank_state[7:4] == 4'h1) else $error("bank one not opened");
    act_space_a: assert property (cmd == 4'h3 |=> cmd != 4'h3) else $error("activates too close");
endmodule // sts_checker

// File: dv/tb_sdram_transient_state_rules.sv
// bench: issuer faces bank logic; a second bank logic gets hand-made pins that break the order
// assumes package timers of one cycle at 10 MHz, mode load two; notes are {illegal, bank_state}, state ff not checked
`timescale 1ns/1ps
module tb_sdram_transient_state_rules;
    import sts_pkg::*;
    logic       mclk = 1'b0, rst = 1'b1, req = 1'b0, req_bank = 1'b0, req_ap = 1'b0, wdone = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic       bdone2 = 1'b0, v2 = 1'b0, p1 = 1'b0, p2 = 1'b0, ack, ill1, acc1, ill2;
    logic [7:0] st1, st2;
    logic [8:0] q[$];
    logic [8:0] note, got;
    int         n_mismatch = 0;
    int         n_compared = 0;
    sts_if if1();
    sts_if if2();
    always #50 mclk = ~mclk;
    sts_cmd_issuer u_sts_cmd_issuer (.mclk(mclk), .rst(rst), .pins(if1), .req(req), .req_op(req_op),
        .req_bank(req_bank), .req_ap(req_ap), .req_write_done(wdone), .ack(ack));
    sts_bank_fsm u_sts_bank_fsm (.mclk(mclk), .rst(rst), .pins(if1), .burst_done(wdone), .bank_state(st1),
        .cmd_illegal(ill1), .cmd_accepted(acc1));
    sts_bank_fsm u_sts_bank_fsm2 (.mclk(mclk), .rst(rst), .pins(if2), .burst_done(bdone2), .bank_state(st2),
        .cmd_illegal(ill2), .cmd_accepted());
    sts_checker u_sts_checker (.mclk(mclk), .rst(rst), .chip_select_n(if1.chip_select_n),
        .row_strobe_n(if1.row_strobe_n), .column_strobe_n(if1.column_strobe_n),
        .write_strobe_n(if1.write_strobe_n), .bank_select_bit(if1.bank_select_bit),
        .bank_state(st1), .cmd_illegal(ill1), .cmd_accepted(acc1));
    task automatic end_sim();
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic issue(input logic [2:0] op, input logic b, input logic ap, input logic [8:0] exp);
        int k;
        req_op = op;
        req_bank = b;
        req_ap = ap;
        req = 1'b1;
        q.push_back(exp);
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(negedge mclk);
        if (k == 20) begin
            $display("BAD ack_wait expected 1 seen 0");
            n_mismatch++;
            end_sim();
        end
        req = 1'b0;
        @(negedge mclk);
    endtask
    task automatic pulse_done();
        wdone = 1'b1;
        @(negedge mclk);
        wdone = 1'b0;
    endtask
    // pins stay put until the next call, so back-to-back commands never rewrite a pin in one step
    task automatic drv2(input logic [3:0] c, input logic b, input logic ap, input logic [8:0] exp);
        {if2.chip_select_n, if2.row_strobe_n, if2.column_strobe_n, if2.write_strobe_n} = c;
        if2.bank_select_bit = b;
        if2.auto_precharge = ap;
        v2 = 1'b1;
        q.push_back(exp);
        @(negedge mclk);
    endtask
    task automatic pad(input int n);
        repeat (n) drv2(4'(4'h8 - $urandom % 3), 1'b0, 1'b0, 9'h0ff);
    endtask
    task automatic recov2(input logic ap, input logic [3:0] c, input logic bad);
        drv2(4'h4, 1'b0, ap, 9'h0ff);
        bdone2 = 1'b1;
        drv2(4'h7, 1'b0, ap, 9'h0ff);
        bdone2 = 1'b0;
        drv2(c, 1'b0, ap, {bad, 8'hff});
        pad(3);
    endtask
    always @(posedge mclk) begin
        p1 <= ack;
        p2 <= v2;
    end
    always @(negedge mclk) begin
        if (p1 || p2) begin
            note = q.pop_front();
            got = p1 ? {ill1, st1} : {ill2, st2};
            n_compared++;
            if (got[8] !== note[8] || (note[7:0] != 8'hff && got[7:0] !== note[7:0])) begin
                n_mismatch++;
                $display("BAD illegal_and_state expected %h seen %h", note, got);
            end
        end
    end
    initial begin
        int b;
        b = $urandom(80865);
        {if2.chip_select_n, if2.row_strobe_n, if2.column_strobe_n, if2.write_strobe_n} = 4'h8;
        if2.bank_select_bit = 1'b0;
        if2.auto_precharge = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        issue(3'h5, 1'b0, 1'b0, 9'h001);
        issue(3'h5, 1'b1, 1'b0, 9'h012);
        issue(3'h4, 1'b0, 1'b0, 9'h0ff);
        pulse_done();
        issue(3'h6, 1'b0, 1'b0, 9'h020);
        issue(3'h4, 1'b1, 1'b1, 9'h0ff);
        pulse_done();
        issue(3'h7, 1'b0, 1'b0, 9'h055);
        for (int i = 0; i < 4; i++) begin
            b = $urandom % 2;
            issue(3'h5, b[0], 1'b0, {1'b0, b[0] ? 8'h10 : 8'h01});
            issue(3'h6, b[0], 1'b0, 9'h000);
        end
        drv2(4'h3, 1'b0, 1'b0, 9'h001);
        drv2(4'h5, 1'b0, 1'b0, 9'h1ff);
        pad(2);
        drv2(4'h3, 1'b1, 1'b0, 9'h012);
        drv2(4'(4'h8 - $urandom % 3), 1'b1, 1'b0, 9'h022);
        pad(2);
        recov2(1'b0, 4'h3, 1'b1);
        recov2(1'b0, 4'h4, 1'b0);
        recov2(1'b1, 4'h5, 1'b1);
        drv2(4'h2, 1'b1, 1'b0, 9'h000);
        drv2(4'h1, 1'b0, 1'b0, 9'h055);
        drv2(4'h2, 1'b0, 1'b0, 9'h1ff);
        pad(3);
        drv2(4'h0, 1'b0, 1'b0, 9'h066);
        drv2(4'h3, 1'b1, 1'b0, 9'h1ff);
        pad(3);
        drv2(4'h3, 1'b1, 1'b0, 9'h010);
        v2 = 1'b0;
        repeat (4) @(negedge mclk);
        end_sim();
    end
endmodule // tb_sdram_transient_state_rules

// File: shared/sts_if.sv
// command pins between the memory controller and the bank state logic
// assumes both ends share mclk
`timescale 1ns/1ps
interface sts_if;
    logic       chip_select_n;
    logic       row_strobe_n;
    logic       column_strobe_n;
    logic       write_strobe_n;
    logic       bank_select_bit;
    logic       auto_precharge;
    modport ctrl (output chip_select_n, output row_strobe_n, output column_strobe_n,
                  output write_strobe_n, output bank_select_bit, output auto_precharge);
    modport dev  (input chip_select_n, input row_strobe_n, input column_strobe_n,
                  input write_strobe_n, input bank_select_bit, input auto_precharge);
endinterface

// File: shared/sts_pkg.sv
// constants, command and bank-state types shared by the command issuer and the bank state logic
// assumes one clock mclk at 10 MHz and an asynchronous active-high reset rst
// Notes on behaviour
// - after activate, non-idle commands wait activation delay
// - burst stop no-op; no commands during activation
// - write recovery: column ok, others illegal
// - auto-precharge recovery: only idle commands, then idle
// - refresh: only idle commands until precharge period
// - mode load: only idle commands until delay
// - inputs sampled only on rising clock edge
// - legality judged by selected bank's own state; refresh and mode load need both banks idle
// - activate other bank after activate-to-activate delay
package sts_pkg;
    localparam int CLK_MHZ = 10;
    localparam int T_RCD_NS = 20;
    localparam int T_DPL_NS = 10;
    localparam int T_DAL_NS = 30;
    localparam int T_RP_NS = 20;
    localparam int T_MCD_CYC = 2;
    localparam int T_RRD_NS = 12;
    localparam int CYC_NS = 1000 / CLK_MHZ;
    localparam int RCD_CYC = (T_RCD_NS + CYC_NS - 1) / CYC_NS > 0 ? (T_RCD_NS + CYC_NS - 1) / CYC_NS : 1;
    localparam int DPL_CYC = (T_DPL_NS + CYC_NS - 1) / CYC_NS > 0 ? (T_DPL_NS + CYC_NS - 1) / CYC_NS : 1;
    localparam int DAL_CYC = (T_DAL_NS + CYC_NS - 1) / CYC_NS > 0 ? (T_DAL_NS + CYC_NS - 1) / CYC_NS : 1;
    localparam int RP_CYC = (T_RP_NS + CYC_NS - 1) / CYC_NS > 0 ? (T_RP_NS + CYC_NS - 1) / CYC_NS : 1;
    localparam int RRD_CYC = (T_RRD_NS + CYC_NS - 1) / CYC_NS > 0 ? (T_RRD_NS + CYC_NS - 1) / CYC_NS : 1;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // command code is {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
    typedef enum logic [2:0] {
        STS_CMD_DESEL, STS_CMD_NOP, STS_CMD_BST, STS_CMD_READ,
        STS_CMD_WRITE, STS_CMD_ACT, STS_CMD_PRE, STS_CMD_REF_MODE
    } sts_cmd_e;

    typedef enum logic [3:0] {
        STS_IDLE, STS_ACTIVATING, STS_ROW_ACTIVE, STS_WRITE_RECOV,
        STS_WRITE_RECOV_AP, STS_REFRESH, STS_MODE_LOAD
    } sts_state_e;

    localparam int NUM_BANKS = 2;

    function automatic logic [3:0] sts_encode(input logic [2:0] op);
        unique case (op)
            3'h0: sts_encode = 4'h8; // deselect
            3'h1: sts_encode = 4'h7; // no-op HHH
            3'h2: sts_encode = 4'h6; // burst stop HHL
            3'h3: sts_encode = 4'h5; // read HLH
            3'h4: sts_encode = 4'h4; // write HLL
            3'h5: sts_encode = 4'h3; // activate LHH
            3'h6: sts_encode = 4'h2; // precharge LHL
            default: sts_encode = 4'h1; // refresh LLH
        endcase
    endfunction
endpackage
